// file: verilog/iccb_clear_bank.sv
// Interrupt clear command bank: self-clearing strobes toward the monitor flags
`timescale 1ns/1ns
module iccb_clear_bank
  import iccb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // One-cycle clear strobes, same bit layout as the monitor registers
  output iccb_clr_t clr_strobe,
  // Interrupt
  output logic irq
);

  iccb_bus_t bus;
  iccb_state_t s_q;
  iccb_state_t s_d;
  logic wr_clear_all;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_clear_all = bus.wr && bus.addr == OFF_CLEAR_ALL && bus.wdata[BIT_CLEAR_ALL];

  always_comb
  begin
    s_d = s_q;
    // Strobes live one cycle only; no write of zero is needed to release them
    s_d.clr = '0;
    s_d.rdata = ZERO8;
    if (wr_clear_all)
    begin
      // Same effect as ones in every writable clear bit
      s_d.clr = '{clk_pll: MASK_CLK_PLL, sync_wd: MASK_SYNC_WD, dig_loop: MASK_DIG_LOOP,
                  hist_lim: MASK_HIST_LIM, ref_in: MASK_REF_IN};
    end
    else if (bus.wr)
    begin
      // Reserved bits are masked away so they can never pulse a flag
      unique case (bus.addr)
        OFF_CLK_PLL_CLR: s_d.clr.clk_pll = bus.wdata & MASK_CLK_PLL;
        OFF_SYNC_WD_CLR: s_d.clr.sync_wd = bus.wdata & MASK_SYNC_WD;
        OFF_DIG_LOOP_CLR: s_d.clr.dig_loop = bus.wdata & MASK_DIG_LOOP;
        OFF_HIST_LIM_CLR: s_d.clr.hist_lim = bus.wdata & MASK_HIST_LIM;
        OFF_REF_IN_CLR: s_d.clr.ref_in = bus.wdata & MASK_REF_IN;
        default: s_d.clr = '0; // Wholly reserved register and unmapped writes
      endcase
    end
    // Local status: write events and clear-all events; set wins over write-one-clear
    if (bus.wr && bus.addr == OFF_IRQ_STATUS)
    begin
      s_d.irq_stat = s_q.irq_stat & ~bus.wdata[IRQ_CLEAR_ALL:IRQ_WRITE];
    end
    if (bus.wr && bus.addr == OFF_IRQ_MASK)
    begin
      s_d.irq_mask = bus.wdata[IRQ_CLEAR_ALL:IRQ_WRITE];
    end
    if (bus.wr && bus.addr != OFF_IRQ_STATUS && bus.addr != OFF_IRQ_MASK)
    begin
      s_d.irq_stat[IRQ_WRITE] = 1'b1;
    end
    if (wr_clear_all)
    begin
      s_d.irq_stat[IRQ_CLEAR_ALL] = 1'b1;
    end
    if (bus.rd)
    begin
      // Clear registers are write-only and read as zero
      if (bus.addr == OFF_IRQ_STATUS)
      begin
        s_d.rdata = DATA_W'(s_q.irq_stat);
      end
      else if (bus.addr == OFF_IRQ_MASK)
      begin
        s_d.rdata = DATA_W'(s_q.irq_mask);
      end
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign clr_strobe = s_q.clr;
  assign irq = s_q.irq;

  // Assertions
  property p_clr_one;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_DIG_LOOP_CLR && reg_wdata[0]) |=> clr_strobe.dig_loop[0];
  endproperty
  a_clr_one: assert property (p_clr_one) else $error("Clear write gave no strobe");

  property p_self_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      !reg_wr |=> clr_strobe == '0;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("Strobe held without write");

  property p_clk_pll;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_CLK_PLL_CLR) |=> clr_strobe.clk_pll == ($past(reg_wdata) & 8'h3f);
  endproperty
  a_clk_pll: assert property (p_clk_pll) else $error("Clock loop clear mismatch");

  property p_sync_wd;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_SYNC_WD_CLR) |=> clr_strobe.sync_wd == ($past(reg_wdata) & 8'h1f);
  endproperty
  a_sync_wd: assert property (p_sync_wd) else $error("Sync clear mismatch");

  property p_dig_loop;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_DIG_LOOP_CLR) |=> clr_strobe.dig_loop == $past(reg_wdata);
  endproperty
  a_dig_loop: assert property (p_dig_loop) else $error("Loop clear mismatch");

  property p_hist;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_HIST_LIM_CLR) |=>
        clr_strobe.hist_lim == ($past(reg_wdata) & 8'h1f);
  endproperty
  a_hist: assert property (p_hist) else $error("History clear mismatch");

  property p_ref_a;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_REF_IN_CLR) |=> clr_strobe.ref_in[2:0] == $past(reg_wdata[2:0]);
  endproperty
  a_ref_a: assert property (p_ref_a) else $error("Input a clear mismatch");

  property p_ref_b;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_REF_IN_CLR) |=> clr_strobe.ref_in[6:4] == $past(reg_wdata[6:4]);
  endproperty
  a_ref_b: assert property (p_ref_b) else $error("Input b clear mismatch");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_b)
      1'b1 |-> (clr_strobe.ref_in[7] == 1'b0 && clr_strobe.ref_in[3] == 1'b0
                && clr_strobe.clk_pll[7:6] == ZERO2 && clr_strobe.sync_wd[7:5] == 3'h0
                && clr_strobe.hist_lim[7:5] == 3'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved clear bit pulsed");

  property p_clear_all;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_CLEAR_ALL && reg_wdata[BIT_CLEAR_ALL]) |=>
        clr_strobe == {8'h3f, 8'h1f, 8'hff, 8'h1f, 8'h77};
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("Clear-all incomplete");

  // A zero write is harmless, so software may rewrite a whole register safely
  property p_zero_write;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_wdata == ZERO8) |=> clr_strobe == '0;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("Zero write pulsed");

  property p_rsvd_reg;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_RSVD_CLR) |=> clr_strobe == '0;
  endproperty
  a_rsvd_reg: assert property (p_rsvd_reg) else $error("Reserved write pulsed");

  property p_ca_other;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_CLEAR_ALL && !reg_wdata[BIT_CLEAR_ALL]) |=> clr_strobe == '0;
  endproperty
  a_ca_other: assert property (p_ca_other) else $error("Other reset bit pulsed");

  property p_iso_clk;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_CLK_PLL_CLR) |=>
        clr_strobe.sync_wd == ZERO8 && clr_strobe.dig_loop == ZERO8
        && clr_strobe.hist_lim == ZERO8 && clr_strobe.ref_in == ZERO8;
  endproperty
  a_iso_clk: assert property (p_iso_clk) else $error("Stray field after loop write");

  property p_iso_sync;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_SYNC_WD_CLR) |=>
        clr_strobe.clk_pll == ZERO8 && clr_strobe.dig_loop == ZERO8
        && clr_strobe.hist_lim == ZERO8 && clr_strobe.ref_in == ZERO8;
  endproperty
  a_iso_sync: assert property (p_iso_sync) else $error("Stray field after sync write");

  property p_iso_dig;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_DIG_LOOP_CLR) |=>
        clr_strobe.clk_pll == ZERO8 && clr_strobe.sync_wd == ZERO8
        && clr_strobe.hist_lim == ZERO8 && clr_strobe.ref_in == ZERO8;
  endproperty
  a_iso_dig: assert property (p_iso_dig) else $error("Stray field after digital write");

  property p_iso_hist;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_HIST_LIM_CLR) |=>
        clr_strobe.clk_pll == ZERO8 && clr_strobe.sync_wd == ZERO8
        && clr_strobe.dig_loop == ZERO8 && clr_strobe.ref_in == ZERO8;
  endproperty
  a_iso_hist: assert property (p_iso_hist) else $error("Stray field after history write");

  property p_iso_ref;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_REF_IN_CLR) |=>
        clr_strobe.clk_pll == ZERO8 && clr_strobe.sync_wd == ZERO8
        && clr_strobe.dig_loop == ZERO8 && clr_strobe.hist_lim == ZERO8;
  endproperty
  a_iso_ref: assert property (p_iso_ref) else $error("Stray field after input write");

  property p_clk_unlock;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_CLK_PLL_CLR && reg_wdata[5]) |=> clr_strobe.clk_pll[5];
  endproperty
  a_clk_unlock: assert property (p_clk_unlock) else $error("Unlock clear lost");

  property p_ref_b_valid;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_REF_IN_CLR && reg_wdata[6]) |=> clr_strobe.ref_in[6];
  endproperty
  a_ref_b_valid: assert property (p_ref_b_valid) else $error("Validated clear lost");

  // Clear registers are write-only; a read must not leak the last command
  property p_rd_clear_reg;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr >= OFF_CLEAR_ALL && reg_addr <= OFF_RSVD_CLR) |=> reg_rdata == ZERO8;
  endproperty
  a_rd_clear_reg: assert property (p_rd_clear_reg) else $error("Clear register read not zero");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == ZERO8;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside its cycle");

  property p_rd_status;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == OFF_IRQ_STATUS) |=> reg_rdata == DATA_W'($past(s_q.irq_stat));
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("Status read mismatch");

  property p_rd_mask;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == OFF_IRQ_MASK) |=> reg_rdata == DATA_W'($past(s_q.irq_mask));
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("Mask read mismatch");

  property p_stat_set;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr != OFF_IRQ_STATUS && reg_addr != OFF_IRQ_MASK) |=>
        s_q.irq_stat[IRQ_WRITE];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("Write event not flagged");

  property p_stat_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_IRQ_STATUS && reg_wdata[IRQ_WRITE]) |=>
        !s_q.irq_stat[IRQ_WRITE];
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("Status bit not cleared");

  property p_stat_sticky;
    @(posedge ref_clk) disable iff (!rst_b)
      (!reg_wr && s_q.irq_stat[IRQ_WRITE]) |=> s_q.irq_stat[IRQ_WRITE];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("Status bit lost");

  property p_ca_stat;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_clear_all |=> s_q.irq_stat[IRQ_CLEAR_ALL];
  endproperty
  a_ca_stat: assert property (p_ca_stat) else $error("Clear-all event not flagged");

  property p_mask_wr;
    @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_IRQ_MASK) |=>
        s_q.irq_mask == $past(reg_wdata[IRQ_CLEAR_ALL:IRQ_WRITE]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("Mask write lost");

  property p_irq_level;
    @(posedge ref_clk) disable iff (!rst_b)
      irq == |(s_q.irq_stat & s_q.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

  c_clear_all: cover property (@(posedge ref_clk) disable iff (!rst_b)
    clr_strobe.sync_wd == 8'h1f);
  c_ref_b: cover property (@(posedge ref_clk) disable iff (!rst_b) clr_strobe.ref_in[6]);
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(irq));
  c_clear_full: cover property (@(posedge ref_clk) disable iff (!rst_b)
    clr_strobe.dig_loop == 8'hff && clr_strobe.ref_in == 8'h77);
  c_rd_status: cover property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && reg_addr == OFF_IRQ_STATUS);
endmodule : iccb_clear_bank

// file: verilog/iccb_pkg.sv
// Package for the interrupt clear command bank
package iccb_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [11:0] OFF_CLEAR_ALL = 12'ha03;
  localparam logic [11:0] OFF_CLK_PLL_CLR = 12'ha04;
  localparam logic [11:0] OFF_SYNC_WD_CLR = 12'ha05;
  localparam logic [11:0] OFF_DIG_LOOP_CLR = 12'ha06;
  localparam logic [11:0] OFF_HIST_LIM_CLR = 12'ha07;
  localparam logic [11:0] OFF_REF_IN_CLR = 12'ha08;
  localparam logic [11:0] OFF_RSVD_CLR = 12'ha09;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'ha10;
  localparam logic [11:0] OFF_IRQ_MASK = 12'ha11;
  // Clear-all bit within the reset functions register
  localparam int unsigned BIT_CLEAR_ALL = 1;
  // Writable bits of each clear register; reserved bits are zero
  localparam logic [7:0] MASK_CLK_PLL = 8'h3f;
  localparam logic [7:0] MASK_SYNC_WD = 8'h1f;
  localparam logic [7:0] MASK_DIG_LOOP = 8'hff;
  localparam logic [7:0] MASK_HIST_LIM = 8'h1f;
  localparam logic [7:0] MASK_REF_IN = 8'h77;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [1:0] ZERO2 = 2'h0;
  localparam int unsigned IRQ_WRITE = 0;
  localparam int unsigned IRQ_CLEAR_ALL = 1;

  typedef struct packed {
    logic [7:0] clk_pll;
    logic [7:0] sync_wd;
    logic [7:0] dig_loop;
    logic [7:0] hist_lim;
    logic [7:0] ref_in;
  } iccb_clr_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iccb_bus_t;

  typedef struct packed {
    iccb_clr_t clr;
    logic [7:0] rdata;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
  } iccb_state_t;
endpackage : iccb_pkg

// file: tb/iccb_clear_bank_tb_top.sv
// Self-checking testbench for the interrupt clear command bank
`timescale 1ns/1ns
module iccb_clear_bank_tb_top
  import iccb_pkg::*;
;
  logic ref_clk;
  logic rst_b;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  iccb_clr_t clr_strobe;
  logic irq;
  int fails;
  int cmp_count;
  logic [7:0] d;
  logic [39:0] e;
  logic [11:0] addr_t [5] = '{OFF_CLK_PLL_CLR, OFF_SYNC_WD_CLR, OFF_DIG_LOOP_CLR,
    OFF_HIST_LIM_CLR, OFF_REF_IN_CLR};
  logic [7:0] mask_t [5] = '{MASK_CLK_PLL, MASK_SYNC_WD, MASK_DIG_LOOP, MASK_HIST_LIM,
    MASK_REF_IN};

  iccb_clear_bank DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clr_strobe(clr_strobe), .irq(irq));

  task check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Returns one ns after the taking edge, where the strobes stand
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task wr_chk(input logic [11:0] a, input logic [7:0] v, input logic [39:0] e);
    wr(a, v);
    check(clr_strobe, e);
    @(posedge ref_clk);
    #1;
    check(clr_strobe, 40'h0);
  endtask : wr_chk

  task irq_chk(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    check({39'h0, irq}, {39'h0, e});
  endtask : irq_chk

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Generous bound: the tests need well under 20 us
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end

  initial
  begin
    rst_b = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Walking one, then all ones, through every field
    for (int i = 0; i < 5; i++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        e = 40'(mask_t[i] & (8'h01 << b)) << (8 * (4 - i));
        wr_chk(addr_t[i], 8'h01 << b, e);
      end
      wr_chk(addr_t[i], 8'hff, 40'(mask_t[i]) << (8 * (4 - i)));
    end
    $display("Test done: field mapping");
    wr_chk(OFF_CLK_PLL_CLR, 8'h00, 40'h0);
    wr_chk(OFF_RSVD_CLR, 8'hff, 40'h0);
    wr_chk(12'h0ff, 8'hff, 40'h0);
    wr_chk(OFF_CLEAR_ALL, 8'hfd, 40'h0);
    e = {MASK_CLK_PLL, MASK_SYNC_WD, MASK_DIG_LOOP, MASK_HIST_LIM, MASK_REF_IN};
    wr_chk(OFF_CLEAR_ALL, 8'h02, e);
    rd(OFF_REF_IN_CLR, d);
    check({32'h0, d}, 40'h0);
    // Status now holds both the write event and the clear-all event
    rd(OFF_IRQ_STATUS, d);
    check({32'h0, d}, 40'h03);
    @(posedge ref_clk);
    #1;
    check({32'h0, reg_rdata}, 40'h0);
    $display("Test done: reserved, clear-all, readback");
    wr(OFF_IRQ_STATUS, 8'h03);
    wr(OFF_IRQ_MASK, 8'h01);
    irq_chk(1'b0);
    wr(OFF_DIG_LOOP_CLR, 8'h81);
    irq_chk(1'b1);
    rd(OFF_IRQ_STATUS, d);
    check({32'h0, d}, 40'h01);
    wr(OFF_IRQ_MASK, 8'h00);
    irq_chk(1'b0);
    wr(OFF_IRQ_MASK, 8'h01);
    irq_chk(1'b1);
    rd(OFF_IRQ_MASK, d);
    check({32'h0, d}, 40'h01);
    wr(OFF_IRQ_STATUS, 8'h01);
    irq_chk(1'b0);
    $display("Test done: interrupt");
    stop_test();
  end
endmodule : iccb_clear_bank_tb_top
